// ==== hw/rcs_control.sv ====
// rcs_control: supervisory state machine and mini converter config register
//
// Contract
// - 8-bit read/write mini converter config register at address 0x0F.
// - bit 7 enables full-duty mode; resets to one.
// - bit 6 enables spread-spectrum switching; resets to zero.
// - bit 5 selects forced continuous conduction, else pulse-skipping; resets zero.
// - bits 4:3 high-side drive: 00 low noise, 11 efficient (reset); never 01/10.
// - bits 2:1 low-side drive: 00 low noise, 11 efficient (reset); never 01/10.
// - power removed, undervoltage or overvoltage lockout sends any state to no power.
// - no power to bias ramp on power; bias ramp to resistor check when mini up.
// - resistor valid and bias good enter bias ready; enable rise starts main ramp.
// - main ramp enables converter with bias good; main good rising enters main on.
// - main on shows both goods; target register change enters servo.
// - servo slews with bias good high, main good low; leaves on completion.
// - bias faults from normal states enter bias reset; delay expiry returns to ramp.
// - with enable high, latch-off faults enter main shutdown; done returns to ready.
// - with enable high, hiccup faults enter main error; timer or internal enable fall exits.
// - register interface only works once bias power good is high.
`timescale 1ns/1ps
`default_nettype none

module rcs_control #(
	parameter logic [15:0] BIAS_RESET_CYCLES = rcs_pkg::BIAS_RESET_CYCLES,
	parameter logic [15:0] HICCUP_CYCLES = rcs_pkg::HICCUP_CYCLES
) (
	// clock and power-on reset
	input wire logic ref_clk,
	input wire logic reset,
	// analog comparators and pins
	input wire rcs_pkg::rcs_status_type status_in,
	// same-clock events from the host side
	input wire logic target_change,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	// register read data
	output logic [7:0] reg_rdata,
	// indicators and rail enables
	output logic bias_power_good,
	output logic main_power_good,
	output logic bias_enable,
	output logic main_enable,
	output rcs_pkg::rcs_state_type state_out,
	// mini converter options
	output rcs_pkg::rcs_mini_cfg_type mini_cfg
);
	rcs_pkg::rcs_status_type sync1_reg;
	rcs_pkg::rcs_status_type st;
	logic enable_prev_reg;
	logic ien_prev_reg;
	logic bias_good_prev_reg;
	logic main_good_prev_reg;
	rcs_pkg::rcs_state_type state_reg;
	rcs_pkg::rcs_state_type state_next;
	logic [15:0] timer_reg;
	logic [7:0] cfg_reg;
	logic [7:0] cfg_next;
	logic power_loss;
	logic bias_fault;
	logic latch_fault;
	logic hiccup_fault;
	logic enable_rise;
	logic ien_fall;
	logic bias_rise;
	logic main_rise;
	logic normal_state;
	logic main_active;
	logic cfg_wr_ok;

	// two-flop synchroniser; the first stage feeds only the second
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= '0;
			st <= '0;
		end else begin
			sync1_reg <= status_in;
			st <= sync1_reg;
		end
	end

	// previous values for edge detection on synchronised levels
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			enable_prev_reg <= 1'b0;
			ien_prev_reg <= 1'b0;
			bias_good_prev_reg <= 1'b0;
			main_good_prev_reg <= 1'b0;
		end else begin
			enable_prev_reg <= st.enable;
			ien_prev_reg <= st.internal_enable;
			bias_good_prev_reg <= st.bias_rails_good;
			main_good_prev_reg <= st.main_good;
		end
	end

	assign enable_rise = st.enable && !enable_prev_reg;
	assign ien_fall = !st.internal_enable && ien_prev_reg;
	assign bias_rise = st.bias_rails_good && !bias_good_prev_reg;
	assign main_rise = st.main_good && !main_good_prev_reg;

	// fault groups
	assign power_loss = !st.power_present || st.uvlo || st.ovlo;
	assign bias_fault = st.mini_ocp || st.mini_ovp || st.mini_uvp || st.aux_uvp
		|| st.freq_out_of_range || st.hard_tsd;
	assign latch_fault = ien_fall || st.uvp_latch || st.sync_err_latch
		|| st.out_ovp || st.out_ocp;
	assign hiccup_fault = st.uvp_hiccup || st.sync_err_hiccup || st.soft_tsd;

	// states in which bias faults are watched
	assign normal_state = state_reg inside {rcs_pkg::ST_BIAS_RAMP, rcs_pkg::ST_FREQ_CHECK,
		rcs_pkg::ST_BIAS_READY, rcs_pkg::ST_MAIN_RAMP, rcs_pkg::ST_MAIN_ON,
		rcs_pkg::ST_SERVO};
	// states in which the main converter can be running
	assign main_active = state_reg inside {rcs_pkg::ST_MAIN_RAMP, rcs_pkg::ST_MAIN_ON,
		rcs_pkg::ST_SERVO};

	// next state; fault checks come first so their order sets priority
	always_comb begin
		state_next = state_reg;
		if (power_loss) begin
			state_next = rcs_pkg::ST_NO_POWER;
		end else if (normal_state && bias_fault) begin
			state_next = rcs_pkg::ST_BIAS_RESET;
		end else if (st.enable && latch_fault
			&& (main_active || state_reg == rcs_pkg::ST_MAIN_ERROR)) begin
			state_next = rcs_pkg::ST_MAIN_SHUTDOWN;
		end else if (st.enable && hiccup_fault && main_active) begin
			state_next = rcs_pkg::ST_MAIN_ERROR;
		end else begin
			unique case (state_reg)
				rcs_pkg::ST_NO_POWER: begin
					state_next = rcs_pkg::ST_BIAS_RAMP;
				end
				rcs_pkg::ST_BIAS_RAMP: begin
					if (st.mini_up) begin
						state_next = rcs_pkg::ST_FREQ_CHECK;
					end
				end
				rcs_pkg::ST_FREQ_CHECK: begin
					// the level also counts so a rail already good is not missed
					if (st.freq_valid && (bias_rise || st.bias_rails_good)) begin
						state_next = rcs_pkg::ST_BIAS_READY;
					end
				end
				rcs_pkg::ST_BIAS_READY: begin
					if (enable_rise) begin
						state_next = rcs_pkg::ST_MAIN_RAMP;
					end
				end
				rcs_pkg::ST_MAIN_RAMP: begin
					if (main_rise) begin
						state_next = rcs_pkg::ST_MAIN_ON;
					end
				end
				rcs_pkg::ST_MAIN_ON: begin
					if (target_change) begin
						state_next = rcs_pkg::ST_SERVO;
					end
				end
				rcs_pkg::ST_SERVO: begin
					if (st.servo_done) begin
						state_next = rcs_pkg::ST_MAIN_ON;
					end
				end
				rcs_pkg::ST_BIAS_RESET: begin
					if (timer_reg == rcs_pkg::TIMER_RESET) begin
						state_next = rcs_pkg::ST_BIAS_RAMP;
					end
				end
				rcs_pkg::ST_MAIN_SHUTDOWN: begin
					if (st.shutdown_done) begin
						state_next = rcs_pkg::ST_BIAS_READY;
					end
				end
				rcs_pkg::ST_MAIN_ERROR: begin
					if (ien_fall) begin
						state_next = rcs_pkg::ST_BIAS_READY;
					end else if (timer_reg == rcs_pkg::TIMER_RESET) begin
						state_next = rcs_pkg::ST_MAIN_RAMP;
					end
				end
				default: begin
					state_next = rcs_pkg::ST_NO_POWER;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= rcs_pkg::ST_NO_POWER;
		end else begin
			state_reg <= state_next;
		end
	end

	// delay counter, loaded on entry and counted down to zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			timer_reg <= rcs_pkg::TIMER_RESET;
		end else if (state_next != state_reg
			&& state_next == rcs_pkg::ST_BIAS_RESET) begin
			timer_reg <= BIAS_RESET_CYCLES - 16'h0001;
		end else if (state_next != state_reg
			&& state_next == rcs_pkg::ST_MAIN_ERROR) begin
			timer_reg <= HICCUP_CYCLES - 16'h0001;
		end else if (timer_reg != rcs_pkg::TIMER_RESET) begin
			timer_reg <= timer_reg - 16'h0001;
		end
	end

	// outputs follow the state being entered so they change with it
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bias_power_good <= 1'b0;
			main_power_good <= 1'b0;
			bias_enable <= 1'b0;
			main_enable <= 1'b0;
			state_out <= rcs_pkg::ST_NO_POWER;
		end else begin
			bias_power_good <= state_next inside {rcs_pkg::ST_BIAS_READY,
				rcs_pkg::ST_MAIN_RAMP, rcs_pkg::ST_MAIN_ON, rcs_pkg::ST_SERVO,
				rcs_pkg::ST_MAIN_SHUTDOWN, rcs_pkg::ST_MAIN_ERROR};
			main_power_good <= state_next == rcs_pkg::ST_MAIN_ON;
			bias_enable <= state_next != rcs_pkg::ST_NO_POWER
				&& state_next != rcs_pkg::ST_BIAS_RESET;
			main_enable <= state_next inside {rcs_pkg::ST_MAIN_RAMP,
				rcs_pkg::ST_MAIN_ON, rcs_pkg::ST_SERVO};
			state_out <= state_next;
		end
	end

	// writes land only while bias is good; unused bit 0 stays zero
	assign cfg_wr_ok = reg_wr && bias_power_good
		&& reg_addr == rcs_pkg::MINI_CFG_ADDR;
	always_comb begin
		cfg_next = cfg_reg;
		if (cfg_wr_ok) begin
			cfg_next[rcs_pkg::FULL_DUTY_BIT] = reg_wdata[rcs_pkg::FULL_DUTY_BIT];
			cfg_next[rcs_pkg::SPREAD_BIT] = reg_wdata[rcs_pkg::SPREAD_BIT];
			cfg_next[rcs_pkg::FORCED_CCM_BIT] = reg_wdata[rcs_pkg::FORCED_CCM_BIT];
			// an invalid mixed drive code keeps the previous setting
			if (reg_wdata[rcs_pkg::HSD_HI] == reg_wdata[rcs_pkg::HSD_LO]) begin
				cfg_next[rcs_pkg::HSD_HI:rcs_pkg::HSD_LO] =
					reg_wdata[rcs_pkg::HSD_HI:rcs_pkg::HSD_LO];
			end
			if (reg_wdata[rcs_pkg::LSD_HI] == reg_wdata[rcs_pkg::LSD_LO]) begin
				cfg_next[rcs_pkg::LSD_HI:rcs_pkg::LSD_LO] =
					reg_wdata[rcs_pkg::LSD_HI:rcs_pkg::LSD_LO];
			end
		end
	end

	// config register; power-on reset restores defaults
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cfg_reg <= rcs_pkg::MINI_CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// registered read data; other addresses read as zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && bias_power_good
			&& reg_addr == rcs_pkg::MINI_CFG_ADDR) begin
			reg_rdata <= cfg_reg;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// decoded options to the mini converter
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			// options show the register defaults during reset, not an all-zero mix
			mini_cfg <= rcs_pkg::rcs_mini_cfg_type'(rcs_pkg::MINI_CFG_RESET[7:1]);
		end else begin
			mini_cfg.full_duty <= cfg_next[rcs_pkg::FULL_DUTY_BIT];
			mini_cfg.spread_spectrum <= cfg_next[rcs_pkg::SPREAD_BIT];
			mini_cfg.forced_ccm <= cfg_next[rcs_pkg::FORCED_CCM_BIT];
			mini_cfg.high_side_drive_strength <= cfg_next[rcs_pkg::HSD_HI:rcs_pkg::HSD_LO];
			mini_cfg.low_side_drive_strength <= cfg_next[rcs_pkg::LSD_HI:rcs_pkg::LSD_LO];
		end
	end

	power_loss_a: assert property (@(posedge ref_clk) disable iff (reset)
		power_loss |=> state_reg == rcs_pkg::ST_NO_POWER)
		else $error("power loss did not reach no power");

	bias_ramp_a: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == rcs_pkg::ST_NO_POWER && !power_loss
		|=> state_reg == rcs_pkg::ST_BIAS_RAMP)
		else $error("no power did not move to bias ramp");

	bias_fault_a: assert property (@(posedge ref_clk) disable iff (reset)
		!power_loss && normal_state && bias_fault
		|=> state_reg == rcs_pkg::ST_BIAS_RESET)
		else $error("bias fault missed");

	main_good_a: assert property (@(posedge ref_clk) disable iff (reset)
		main_power_good |-> bias_power_good && state_reg == rcs_pkg::ST_MAIN_ON)
		else $error("main good outside main on");

	servo_flags_a: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == rcs_pkg::ST_SERVO |-> bias_power_good && !main_power_good)
		else $error("servo indicator levels wrong");

	main_enable_a: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == rcs_pkg::ST_MAIN_RAMP |-> main_enable && bias_power_good)
		else $error("main ramp without enable");

	reset_delay_a: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(state_reg == rcs_pkg::ST_BIAS_RESET)
		|-> timer_reg == BIAS_RESET_CYCLES - 16'h0001)
		else $error("bias reset delay not loaded");

	hiccup_exit_a: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == rcs_pkg::ST_MAIN_ERROR && timer_reg == rcs_pkg::TIMER_RESET
		&& !power_loss && !bias_fault && !latch_fault
		|=> state_reg == rcs_pkg::ST_MAIN_RAMP)
		else $error("hiccup expiry did not restart");

	cfg_guard_a: assert property (@(posedge ref_clk) disable iff (reset)
		!bias_power_good |=> $stable(cfg_reg))
		else $error("config changed before bias good");

	drive_code_a: assert property (@(posedge ref_clk) disable iff (reset)
		cfg_reg[rcs_pkg::HSD_HI] == cfg_reg[rcs_pkg::HSD_LO]
		&& cfg_reg[rcs_pkg::LSD_HI] == cfg_reg[rcs_pkg::LSD_LO])
		else $error("invalid drive strength code held");
endmodule

`default_nettype wire

// ==== hw/rcs_pkg.sv ====
// rcs_pkg: constants and types for the regulator control state machine
package rcs_pkg;
	// register map
	localparam logic [7:0] MINI_CFG_ADDR = 8'h0f;
	localparam logic [7:0] MINI_CFG_RESET = 8'h9e;
	// field positions inside mini_buck_config
	localparam int FULL_DUTY_BIT = 7;
	localparam int SPREAD_BIT = 6;
	localparam int FORCED_CCM_BIT = 5;
	localparam int HSD_HI = 4;
	localparam int HSD_LO = 3;
	localparam int LSD_HI = 2;
	localparam int LSD_LO = 1;
	localparam logic [1:0] DRIVE_LOW_NOISE = 2'h0;
	localparam logic [1:0] DRIVE_EFFICIENT = 2'h3;
	// delay times in ns and cycles at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIAS_RESET_DELAY_NS = 1000;
	localparam int HICCUP_DELAY_NS = 5000;
	localparam int TIMER_W = 16;
	localparam logic [TIMER_W-1:0] BIAS_RESET_CYCLES =
		TIMER_W'((BIAS_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] HICCUP_CYCLES =
		TIMER_W'((HICCUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;

	// controller states
	typedef enum logic [3:0] {
		ST_NO_POWER,
		ST_BIAS_RAMP,
		ST_FREQ_CHECK,
		ST_BIAS_READY,
		ST_MAIN_RAMP,
		ST_MAIN_ON,
		ST_SERVO,
		ST_BIAS_RESET,
		ST_MAIN_SHUTDOWN,
		ST_MAIN_ERROR
	} rcs_state_type;

	// analog status comparators, asynchronous to ref_clk
	typedef struct packed {
		logic power_present;
		logic uvlo;
		logic ovlo;
		logic mini_up;
		logic freq_valid;
		logic freq_out_of_range;
		logic bias_rails_good;
		logic main_good;
		logic mini_ocp;
		logic mini_ovp;
		logic mini_uvp;
		logic aux_uvp;
		logic hard_tsd;
		logic soft_tsd;
		logic uvp_latch;
		logic uvp_hiccup;
		logic sync_err_latch;
		logic sync_err_hiccup;
		logic out_ovp;
		logic out_ocp;
		logic shutdown_done;
		logic servo_done;
		logic enable;
		logic internal_enable;
	} rcs_status_type;

	// decoded mini converter options
	typedef struct packed {
		logic full_duty;
		logic spread_spectrum;
		logic forced_ccm;
		logic [1:0] high_side_drive_strength;
		logic [1:0] low_side_drive_strength;
	} rcs_mini_cfg_type;
endpackage

// ==== testbench/rcs_analog_model.sv ====
// rcs_analog_model: behavioural rails and comparators around the control logic
`timescale 1ns/1ps
`default_nettype none

module rcs_analog_model (
	// clock
	input wire logic ref_clk,
	// pin levels and faults set by the bench
	input wire rcs_pkg::rcs_status_type cmd,
	// rail enables from the device
	input wire logic bias_enable,
	input wire logic main_enable,
	// comparator levels seen by the device
	output rcs_pkg::rcs_status_type status
);
	logic [3:0] bias_ramp_reg;
	logic [3:0] main_ramp_reg;

	// rails need a few clocks to settle, so the device never sees an instant rail
	always_ff @(posedge ref_clk) begin
		bias_ramp_reg <= {bias_ramp_reg[2:0], bias_enable & cmd.power_present};
		main_ramp_reg <= {main_ramp_reg[2:0], main_enable};
	end

	// mini rail rises before the bias good comparator, so the check state is seen
	always_comb begin
		status = cmd;
		status.mini_up = bias_ramp_reg[1];
		status.bias_rails_good = bias_ramp_reg[3];
		status.main_good = main_ramp_reg[3];
	end
endmodule
`default_nettype wire

// ==== testbench/rcs_control_bench.sv ====
// rcs_control_bench: directed tests of the regulator control state machine
`timescale 1ns/1ps
`default_nettype none

module rcs_control_bench;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic target_change = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	rcs_pkg::rcs_status_type st = '0;
	rcs_pkg::rcs_status_type status_in;
	logic [7:0] reg_rdata;
	logic bias_power_good;
	logic main_power_good;
	logic bias_enable;
	logic main_enable;
	rcs_pkg::rcs_state_type state_out;
	rcs_pkg::rcs_mini_cfg_type mini_cfg;
	int miscompares = 0;
	int cmp_count = 0;
	logic [7:0] wv [4] = '{8'hff, 8'h6a, 8'h00, 8'h92};
	logic [7:0] ev [4] = '{8'hfe, 8'h7e, 8'h00, 8'h80};

	// short delays keep the run brief
	rcs_control #(.BIAS_RESET_CYCLES(16'h0004), .HICCUP_CYCLES(16'h0008)) dut (
		.ref_clk(ref_clk), .reset(reset), .status_in(status_in),
		.target_change(target_change), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.bias_power_good(bias_power_good), .main_power_good(main_power_good),
		.bias_enable(bias_enable), .main_enable(main_enable),
		.state_out(state_out), .mini_cfg(mini_cfg));

	rcs_analog_model model (.ref_clk(ref_clk), .cmd(st), .bias_enable(bias_enable),
		.main_enable(main_enable), .status(status_in));

	// 100 MHz clock
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	// one comparison, counted
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// register write strobe, one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask

	// register read strobe; data stands only the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		chk("reg_rdata", exp, reg_rdata);
	endtask

	// bounded wait for a state, then {bias_enable, bias good, main good, main_enable}
	task automatic go(input rcs_pkg::rcs_state_type exp, input logic [3:0] ind);
		for (int i = 0; i < 100 && state_out !== exp; i++) begin
			@(negedge ref_clk);
		end
		chk("state_out", 8'(exp), 8'(state_out));
		chk("indicators", {4'h0, ind},
			{4'h0, bias_enable, bias_power_good, main_power_good, main_enable});
	endtask

	// toggle the masked status bits, wait for the state they force, then toggle them back
	task automatic hit(input rcs_pkg::rcs_status_type m, input rcs_pkg::rcs_state_type exp,
		input logic [3:0] ind);
		st = st ^ m;
		go(exp, ind);
		st = st ^ m;
	endtask

	// a fresh enable rise from bias ready runs the converter up to main on
	task automatic rerun;
		st.enable = 1'b0;
		repeat (4) @(negedge ref_clk);
		st.enable = 1'b1;
		go(rcs_pkg::ST_MAIN_ON, 4'hf);
	endtask

	// from main on, a latch-off source shuts down, then completion returns to bias ready
	task automatic latch_off(input rcs_pkg::rcs_status_type m);
		rerun();
		hit(m, rcs_pkg::ST_MAIN_SHUTDOWN, 4'hc);
		st.shutdown_done = 1'b1;
		go(rcs_pkg::ST_BIAS_READY, 4'hc);
		st.shutdown_done = 1'b0;
	endtask

	// a fault that drops the bias rails, then the climb back to bias ready
	task automatic recover(input rcs_pkg::rcs_status_type m, input rcs_pkg::rcs_state_type exp);
		hit(m, exp, 4'h0);
		go(rcs_pkg::ST_BIAS_READY, 4'hc);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		results();
	end

	initial begin
		st.internal_enable = 1'b1;
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		@(negedge ref_clk);
		go(rcs_pkg::ST_NO_POWER, 4'h0);
		chk("mini_cfg", rcs_pkg::MINI_CFG_RESET, {mini_cfg, 1'b0});
		wr(8'h0f, 8'h00);
		rd(8'h0f, 8'h00);
		chk("mini_cfg", rcs_pkg::MINI_CFG_RESET, {mini_cfg, 1'b0});
		$display("test reset done");
		// power arrives, bias rails come up
		st.power_present = 1'b1;
		st.freq_valid = 1'b1;
		go(rcs_pkg::ST_BIAS_RAMP, 4'h8);
		go(rcs_pkg::ST_FREQ_CHECK, 4'h8);
		go(rcs_pkg::ST_BIAS_READY, 4'hc);
		$display("test power up done");
		// register reads, writes, invalid drive codes, unmapped address
		rd(8'h0f, rcs_pkg::MINI_CFG_RESET);
		for (int k = 0; k < 4; k++) begin
			wr(8'h0f, wv[k]);
			rd(8'h0f, ev[k]);
			chk("mini_cfg", ev[k], {mini_cfg, 1'b0});
		end
		wr(8'h0e, 8'hff);
		rd(8'h0e, 8'h00);
		rd(8'h0f, 8'h80);
		$display("test register done");
		// main converter ramp, on, servo
		st.enable = 1'b1;
		go(rcs_pkg::ST_MAIN_RAMP, 4'hd);
		go(rcs_pkg::ST_MAIN_ON, 4'hf);
		@(negedge ref_clk);
		target_change = 1'b1;
		@(negedge ref_clk);
		target_change = 1'b0;
		go(rcs_pkg::ST_SERVO, 4'hd);
		st.servo_done = 1'b1;
		go(rcs_pkg::ST_MAIN_ON, 4'hf);
		st.servo_done = 1'b0;
		$display("test main path done");
		// hiccup fault holds for the timer, then restarts
		st.uvp_hiccup = 1'b1;
		go(rcs_pkg::ST_MAIN_ERROR, 4'hc);
		st.uvp_hiccup = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("state_out", 8'(rcs_pkg::ST_MAIN_ERROR), 8'(state_out));
		go(rcs_pkg::ST_MAIN_RAMP, 4'hd);
		go(rcs_pkg::ST_MAIN_ON, 4'hf);
		$display("test hiccup done");
		// latch-off fault, then shutdown completion
		st.out_ovp = 1'b1;
		go(rcs_pkg::ST_MAIN_SHUTDOWN, 4'hc);
		st.out_ovp = 1'b0;
		st.shutdown_done = 1'b1;
		go(rcs_pkg::ST_BIAS_READY, 4'hc);
		st.shutdown_done = 1'b0;
		st.enable = 1'b0;
		repeat (4) @(negedge ref_clk);
		st.enable = 1'b1;
		go(rcs_pkg::ST_MAIN_ON, 4'hf);
		$display("test latch off done");
		// bias fault beats a simultaneous latch fault
		st.out_ovp = 1'b1;
		st.mini_ocp = 1'b1;
		go(rcs_pkg::ST_BIAS_RESET, 4'h0);
		st.out_ovp = 1'b0;
		st.mini_ocp = 1'b0;
		go(rcs_pkg::ST_BIAS_RAMP, 4'h8);
		go(rcs_pkg::ST_BIAS_READY, 4'hc);
		$display("test priority done");
		// the other latch-off sources; a hiccup source raised with one must lose
		latch_off('{uvp_latch: 1'b1, default: 1'b0});
		latch_off('{sync_err_latch: 1'b1, default: 1'b0});
		latch_off('{out_ocp: 1'b1, soft_tsd: 1'b1, default: 1'b0});
		latch_off('{internal_enable: 1'b1, default: 1'b0});
		$display("test latch sources done");
		// other hiccup sources; internal enable falling cuts the wait short
		rerun();
		hit('{sync_err_hiccup: 1'b1, default: 1'b0}, rcs_pkg::ST_MAIN_ERROR, 4'hc);
		go(rcs_pkg::ST_MAIN_RAMP, 4'hd);
		go(rcs_pkg::ST_MAIN_ON, 4'hf);
		hit('{soft_tsd: 1'b1, default: 1'b0}, rcs_pkg::ST_MAIN_ERROR, 4'hc);
		st.enable = 1'b0;
		st.internal_enable = 1'b0;
		go(rcs_pkg::ST_BIAS_READY, 4'hc);
		st.internal_enable = 1'b1;
		$display("test hiccup sources done");
		// the other bias faults, then power loss over a bias fault and power removal
		recover('{mini_ovp: 1'b1, default: 1'b0}, rcs_pkg::ST_BIAS_RESET);
		recover('{mini_uvp: 1'b1, default: 1'b0}, rcs_pkg::ST_BIAS_RESET);
		recover('{aux_uvp: 1'b1, default: 1'b0}, rcs_pkg::ST_BIAS_RESET);
		recover('{freq_out_of_range: 1'b1, default: 1'b0}, rcs_pkg::ST_BIAS_RESET);
		recover('{hard_tsd: 1'b1, default: 1'b0}, rcs_pkg::ST_BIAS_RESET);
		recover('{ovlo: 1'b1, hard_tsd: 1'b1, default: 1'b0}, rcs_pkg::ST_NO_POWER);
		recover('{power_present: 1'b1, default: 1'b0}, rcs_pkg::ST_NO_POWER);
		$display("test fault sources done");
		// lockout drops everything
		st.uvlo = 1'b1;
		go(rcs_pkg::ST_NO_POWER, 4'h0);
		$display("test lockout done");
		// a mid-run reset brings the options back to their defaults at once
		@(negedge ref_clk);
		reset = 1'b1;
		@(negedge ref_clk);
		chk("mini_cfg", rcs_pkg::MINI_CFG_RESET, {mini_cfg, 1'b0});
		chk("indicators", 8'h00,
			{4'h0, bias_enable, bias_power_good, main_power_good, main_enable});
		reset = 1'b0;
		@(negedge ref_clk);
		go(rcs_pkg::ST_NO_POWER, 4'h0);
		$display("test mid reset done");
		results();
	end
endmodule
`default_nettype wire
